// File: hw/aspwm_top.sv
// Analog-scaled PWM block with its AXI4-Lite register port.
// Assumes input_level_i and enable_i are pins; period_ext_i is on this clock.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module aspwm_top #(
   parameter int BASE_CYC = aspwm_pkg::BASE_CYC,
   parameter int LVL_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Pins
   input wire logic enable_i,
   input wire logic [LVL_W-1:0] input_level_i,
   input wire logic [15:0] period_ext_i,
   output logic pwm_o,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   typedef struct packed {
      logic [LVL_W-1:0] lvl_m;
      logic [LVL_W-1:0] lvl_s;
      logic en_m;
      logic en_s;
      logic en_p;
      logic [5:0] ctrl;
      logic [31:0] gain;
      logic [31:0] offset;
      logic [31:0] min;
      logic [31:0] max;
      logic [15:0] period;
      aspwm_pkg::aspwm_state_e st;
      logic [39:0] elapsed;
      logic [39:0] per_lat;
      logic [31:0] v_lat;
      logic [31:0] min_lat;
      logic [31:0] max_lat;
      logic pwm;
      logic aw_have;
      logic [7:0] awaddr;
      logic awready;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } aspwm_top_s;

   aspwm_top_s s_q, s_d;
   logic signed [31:0] actual;
   logic tick;
   logic start;
   logic [18:0] mult;
   logic [15:0] per_src;
   logic [39:0] per_ticks;
   logic signed [63:0] lhs;
   logic signed [63:0] rhs;
   logic high;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Byte-lane merge of a write into the old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Out-of-range writes saturate rather than wrap
   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lim);
      logic [31:0] r;
      r = v;
      if ($signed(v) > $signed(lim)) begin
         r = lim;
      end else if ($signed(v) < -$signed(lim)) begin
         r = -lim;
      end
      return r;
   endfunction

   // ****************************************************************
   // Scaling and period source
   // ****************************************************************
   aspwm_scale u_scale (
      .level_i (16'(signed'(s_q.lvl_s))),
      .gain_i (s_q.gain),
      .offset_i (s_q.offset),
      .actual_o (actual)
   );

   aspwm_tick #(
      .CYC (BASE_CYC)
   ) u_tick (
      .clk_i (clk_i),
      .reset_i (reset_i),
      .clear_i (start),
      .tick_o (tick)
   );

   assign start = s_q.en_s && !s_q.en_p;

   // Timebase and source select; decimals field is not read here
   always_comb begin
      case (s_q.ctrl[aspwm_pkg::CTRL_TB_LSB +: 2])
         2'h0: mult = aspwm_pkg::MULT_10MS;
         2'h1: mult = aspwm_pkg::MULT_SEC;
         2'h2: mult = aspwm_pkg::MULT_MIN;
         default: mult = aspwm_pkg::MULT_HOUR;
      endcase
      per_src = s_q.ctrl[aspwm_pkg::CTRL_PSEL_BIT] ? period_ext_i : s_q.period;
      per_ticks = 40'(per_src) * 40'(mult);
      if (per_ticks == 40'h00_0000_0000) begin
         per_ticks = 40'h00_0000_0001;                      // Zero period acts as one 10 ms base unit, whatever the timebase
      end
   end

   // ****************************************************************
   // Next state: bus slave and modulator
   // ****************************************************************
   always_comb begin
      logic [31:0] old;
      logic [31:0] wv;
      s_d = s_q;
      old = 32'h0000_0000;
      wv = 32'h0000_0000;
      // Two flops before anything looks at input_level_i or enable_i
      s_d.lvl_m = input_level_i;
      s_d.lvl_s = s_q.lvl_m;
      s_d.en_m = enable_i;
      s_d.en_s = s_q.en_m;
      s_d.en_p = s_q.en_s;

      // Write completes once both address and data are held
      if (s_q.aw_have && s_q.w_have) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = aspwm_pkg::RESP_OKAY;
         case (s_q.awaddr)
            aspwm_pkg::OFF_CTRL: old = 32'(s_q.ctrl);
            aspwm_pkg::OFF_GAIN: old = s_q.gain;
            aspwm_pkg::OFF_OFFSET: old = s_q.offset;
            aspwm_pkg::OFF_MIN: old = s_q.min;
            aspwm_pkg::OFF_MAX: old = s_q.max;
            aspwm_pkg::OFF_PERIOD: old = 32'(s_q.period);
            default: old = 32'h0000_0000;
         endcase
         wv = merge(old, s_q.wdata, s_q.wstrb);
         case (s_q.awaddr)
            aspwm_pkg::OFF_CTRL: s_d.ctrl = wv[5:0];
            aspwm_pkg::OFF_GAIN: s_d.gain = clamp(wv, aspwm_pkg::GAIN_LIM);
            aspwm_pkg::OFF_OFFSET: s_d.offset = clamp(wv, aspwm_pkg::OFFSET_LIM);
            aspwm_pkg::OFF_MIN: s_d.min = clamp(wv, aspwm_pkg::LIMIT_LIM);
            aspwm_pkg::OFF_MAX: s_d.max = clamp(wv, aspwm_pkg::LIMIT_LIM);
            aspwm_pkg::OFF_PERIOD: s_d.period = wv[15:0];
            aspwm_pkg::OFF_STATUS, aspwm_pkg::OFF_ACTUAL: s_d.bresp = aspwm_pkg::RESP_OKAY;
            default: s_d.bresp = aspwm_pkg::RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr = {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      // One write in flight: no new address or data until the answer is taken
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      // Read answers one cycle after the address is taken
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = aspwm_pkg::RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'h0})
            aspwm_pkg::OFF_CTRL: s_d.rdata = 32'(s_q.ctrl);
            aspwm_pkg::OFF_GAIN: s_d.rdata = s_q.gain;
            aspwm_pkg::OFF_OFFSET: s_d.rdata = s_q.offset;
            aspwm_pkg::OFF_MIN: s_d.rdata = s_q.min;
            aspwm_pkg::OFF_MAX: s_d.rdata = s_q.max;
            aspwm_pkg::OFF_PERIOD: s_d.rdata = 32'(s_q.period);
            aspwm_pkg::OFF_STATUS: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rdata[aspwm_pkg::STAT_OUT_BIT] = s_q.pwm;
               s_d.rdata[aspwm_pkg::STAT_RUN_BIT] = (s_q.st == aspwm_pkg::ASPWM_RUN);
            end
            aspwm_pkg::OFF_ACTUAL: s_d.rdata = actual;
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = aspwm_pkg::RESP_SLVERR;
            end
         endcase
      end
      s_d.arready = !s_d.rvalid;

      // Period timer; operands are latched per period so a pulse never tears
      case (s_q.st)
         aspwm_pkg::ASPWM_IDLE: begin
            if (start) begin
               s_d.st = aspwm_pkg::ASPWM_RUN;
            end
         end
         aspwm_pkg::ASPWM_RUN: begin
            if (tick) begin
               if (s_q.elapsed + 40'h00_0000_0001 >= s_q.per_lat) begin
                  s_d.elapsed = 40'h00_0000_0000;
                  s_d.v_lat = actual;
                  s_d.min_lat = s_q.min;
                  s_d.max_lat = s_q.max;
                  s_d.per_lat = per_ticks;
               end else begin
                  s_d.elapsed = s_q.elapsed + 40'h00_0000_0001;
               end
            end
         end
         default: s_d.st = aspwm_pkg::ASPWM_IDLE;
      endcase
      if (start) begin
         s_d.elapsed = 40'h00_0000_0000;
         s_d.v_lat = actual;
         s_d.min_lat = s_q.min;
         s_d.max_lat = s_q.max;
         s_d.per_lat = per_ticks;
      end
      if (!s_q.en_s) begin
         s_d.st = aspwm_pkg::ASPWM_IDLE;
      end

      // High first, then low: high while elapsed*span < period*(v-min)
      lhs = 64'(s_d.elapsed) * 64'($signed(s_d.max_lat) - $signed(s_d.min_lat));
      rhs = 64'(s_d.per_lat) * 64'($signed(s_d.v_lat) - $signed(s_d.min_lat));
      if ($signed(s_d.v_lat) >= $signed(s_d.max_lat)) begin
         high = 1'b1;
      end else if ($signed(s_d.v_lat) <= $signed(s_d.min_lat)) begin
         high = 1'b0;
      end else begin
         high = lhs < rhs;
      end
      s_d.pwm = (s_d.st == aspwm_pkg::ASPWM_RUN) && high;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q <= '0;
         s_q.ctrl <= aspwm_pkg::CTRL_RST;
         s_q.gain <= aspwm_pkg::GAIN_RST;
         s_q.offset <= aspwm_pkg::OFFSET_RST;
         s_q.min <= aspwm_pkg::MIN_RST;
         s_q.max <= aspwm_pkg::MAX_RST;
         s_q.period <= aspwm_pkg::PERIOD_RST;
         s_q.st <= aspwm_pkg::ASPWM_IDLE;
         s_q.per_lat <= 40'h00_0000_0001;
      end else begin
         s_q <= s_d;
      end
   end

   assign pwm_o = s_q.pwm;
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic run_q;
   assign run_q = (s_q.st == aspwm_pkg::ASPWM_RUN);

   a_edge_starts: assert property (@(posedge clk_i) disable iff (reset_i)
      start |=> run_q && s_q.elapsed == 40'h00_0000_0000)
      else $error("enable edge did not start a period");

   a_latch_scaled: assert property (@(posedge clk_i) disable iff (reset_i)
      start |=> s_q.v_lat == $past(actual))
      else $error("period did not latch the scaled value");

   a_gain_bound: assert property (@(posedge clk_i) disable iff (reset_i)
      $signed(s_q.gain) <= 1000 && $signed(s_q.gain) >= -1000)
      else $error("gain out of range");

   a_offset_bound: assert property (@(posedge clk_i) disable iff (reset_i)
      $signed(s_q.offset) <= 10000 && $signed(s_q.offset) >= -10000)
      else $error("offset out of range");

   a_limit_bound: assert property (@(posedge clk_i) disable iff (reset_i)
      $signed(s_q.min) >= -20000 && $signed(s_q.min) <= 20000 &&
      $signed(s_q.max) >= -20000 && $signed(s_q.max) <= 20000)
      else $error("limit out of range");

   a_wrap_restart: assert property (@(posedge clk_i) disable iff (reset_i)
      run_q && s_q.en_s && tick && s_q.elapsed + 40'h00_0000_0001 >= s_q.per_lat
      |=> run_q && s_q.elapsed == 40'h00_0000_0000)
      else $error("period did not wrap");

   a_full_high: assert property (@(posedge clk_i) disable iff (reset_i)
      run_q && s_q.en_s && !start && $signed(s_q.v_lat) >= $signed(s_q.max_lat)
      |-> pwm_o)
      else $error("value at max but output low");

   a_low_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
      !s_q.en_s && !s_q.en_m |=> !pwm_o [*2])
      else $error("output high while disabled");

   a_high_first: assert property (@(posedge clk_i) disable iff (reset_i)
      run_q && !pwm_o && s_q.en_s && !tick && !start |=> !pwm_o)
      else $error("output rose inside a period");

   a_bresp_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      s_q.bvalid && !s_axi_bready |=> s_q.bvalid && $stable(s_q.bresp))
      else $error("write answer dropped early");

endmodule

`default_nettype wire

// File: hw/aspwm_pkg.sv
// Constants, register map and types for the analog-scaled PWM block.
// Assumes a single 20 MHz clock and an AXI4-Lite register port.

`default_nettype none

package aspwm_pkg;

   // ****************************************************************
   // Clock and timebase
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int BASE_TIME_NS = 10000000;                 // 10 ms base unit
   localparam int BASE_CYC = BASE_TIME_NS / CLK_PERIOD_NS;
   localparam logic [18:0] MULT_10MS = 19'h00001;
   localparam logic [18:0] MULT_SEC = 19'h00064;
   localparam logic [18:0] MULT_MIN = 19'h01770;
   localparam logic [18:0] MULT_HOUR = 19'h57e40;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_GAIN = 8'h04;
   localparam logic [7:0] OFF_OFFSET = 8'h08;
   localparam logic [7:0] OFF_MIN = 8'h0c;
   localparam logic [7:0] OFF_MAX = 8'h10;
   localparam logic [7:0] OFF_PERIOD = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_ACTUAL = 8'h1c;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CTRL_PSEL_BIT = 0;
   localparam int CTRL_TB_LSB = 1;
   localparam int CTRL_DEC_LSB = 4;
   localparam int CTRL_W = 6;
   localparam int STAT_OUT_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [31:0] GAIN_RST = 32'h0000_0064;      // 1.00
   localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
   localparam logic [31:0] MIN_RST = 32'h0000_0000;
   localparam logic [31:0] MAX_RST = 32'h0000_03e8;
   localparam logic [15:0] PERIOD_RST = 16'h0064;

   // ****************************************************************
   // Value limits
   // ****************************************************************
   localparam logic [31:0] GAIN_LIM = 32'h0000_03e8;      // 10.00 in hundredths
   localparam logic [31:0] OFFSET_LIM = 32'h0000_2710;
   localparam logic [31:0] LIMIT_LIM = 32'h0000_4e20;
   localparam logic [31:0] GAIN_SCALE = 32'h0000_0064;

   // ****************************************************************
   // Bus answers and states
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      ASPWM_IDLE,
      ASPWM_RUN
   } aspwm_state_e;

endpackage

`default_nettype wire

// File: hw/aspwm_tick.sv
// Base-unit tick generator for the PWM period timer.
// Assumes clear_i comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module aspwm_tick #(
   parameter int CYC = aspwm_pkg::BASE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Control
   input wire logic clear_i,
   output logic tick_o
);

   typedef struct packed {
      logic [31:0] cnt;
   } aspwm_tick_s;

   aspwm_tick_s s_q, s_d;

   // ****************************************************************
   // Counter
   // ****************************************************************
   assign tick_o = (s_q.cnt == 32'(CYC - 1)) && !clear_i;

   // Clear realigns the phase with a fresh period start
   always_comb begin
      s_d = s_q;
      if (clear_i || tick_o) begin
         s_d.cnt = 32'h0000_0000;
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_tick_spacing: assert property (@(posedge clk_i) disable iff (reset_i)
      tick_o |=> !tick_o || (CYC == 1))
      else $error("tick pulses too close");

endmodule

`default_nettype wire

// File: hw/aspwm_scale.sv
// Gain and offset scaling of the sampled input level.
// Purely combinational; inputs come from registers on the caller's clock.
`timescale 1ns/1ps
`default_nettype none

module aspwm_scale (
   // Operands
   input wire logic signed [15:0] level_i,
   input wire logic signed [31:0] gain_i,
   input wire logic signed [31:0] offset_i,
   // Result
   output logic signed [31:0] actual_o
);

   logic signed [47:0] prod;
   logic signed [47:0] scaled;

   // ****************************************************************
   // Level times gain in hundredths, then offset
   // ****************************************************************
   // Division truncates toward zero; gain is fixed point with two decimals
   always_comb begin
      prod = 48'(level_i) * 48'(gain_i);
      scaled = prod / 48'sh0000_0000_0064;
      actual_o = 32'(scaled) + offset_i;
   end

endmodule

`default_nettype wire

// File: tb/test_aspwm_top.sv
// Self-checking bench for the analog-scaled PWM block.
// Drives pins and the AXI4-Lite port itself; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module test_aspwm_top;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam int B = 4;                 // Short base tick keeps runs brief
   logic clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic enable_i = 1'h0;
   logic [15:0] input_level_i = 16'h0000;
   logic [15:0] period_ext_i = 16'h0005;
   logic pwm_o;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'h0;
   logic wv = 1'h0;
   logic bre = 1'h0;
   logic arv = 1'h0;
   logic rre = 1'h0;
   logic awr, wr, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rd;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;

   // Clock
   always #25 clk_i = ~clk_i;

   aspwm_top #(.BASE_CYC(B), .LVL_W(16)) DUT (
      .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
      .input_level_i(input_level_i), .period_ext_i(period_ext_i), .pwm_o(pwm_o),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre)
   );

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog: a hung handshake would otherwise stall forever
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   // ****************************************************************
   // Bus cycles
   // ****************************************************************
   // Address and data offered together, each dropped when taken
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ga, gw;
      ga = 1'h0;
      gw = 1'h0;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bre <= 1'h1;
      while (!(ga && gw)) begin
         @(posedge clk_i);
         if (awv && awr) begin
            ga = 1'h1;
            awv <= 1'h0;
         end
         if (wv && wr) begin
            gw = 1'h1;
            wv <= 1'h0;
         end
      end
      do @(posedge clk_i); while (bv !== 1'h1);
      bre <= 1'h0;
      chk({30'h0, br}, {30'h0, er});
      @(posedge clk_i);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      ara <= a;
      arv <= 1'h1;
      rre <= 1'h1;
      do @(posedge clk_i); while (arr !== 1'h1);
      arv <= 1'h0;
      do @(posedge clk_i); while (rv !== 1'h1);
      rre <= 1'h0;
      chk(rd, ed);
      chk({30'h0, rr}, {30'h0, er});
      @(posedge clk_i);
   endtask

   // ****************************************************************
   // PWM measurement
   // ****************************************************************
   // Counts high cycles over two whole periods; phase does not matter
   task automatic run_pwm(input logic [15:0] lvl, input int v, input int lo, input int hi,
                          input int pt);
      int hi_t, cnt;
      hi_t = 0;
      cnt = 0;
      for (int e = 0; e < pt; e++) if (e * (hi - lo) < pt * (v - lo)) hi_t++;
      input_level_i <= lvl;
      repeat (3) @(posedge clk_i);
      chk({31'h0, pwm_o}, 32'h0);
      enable_i <= 1'h1;
      repeat (5) @(posedge clk_i);
      chk({31'h0, pwm_o}, {31'h0, hi_t > 0});
      repeat (2 * pt * B) begin
         @(posedge clk_i);
         if (pwm_o === 1'h1) cnt++;
      end
      chk(32'(cnt), 32'(2 * hi_t * B));
      // Status only steady when the output never toggles
      if (hi_t == 0 || hi_t == pt) begin
         rd_reg(aspwm_pkg::OFF_STATUS, {30'h0, 1'h1, hi_t > 0}, aspwm_pkg::RESP_OKAY);
      end
      enable_i <= 1'h0;
      repeat (5) @(posedge clk_i);
      chk({31'h0, pwm_o}, 32'h0);
      rd_reg(aspwm_pkg::OFF_STATUS, 32'h0, aspwm_pkg::RESP_OKAY);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Gain reset value, saturating limits, unmapped place
   task automatic t_regs();
      rd_reg(aspwm_pkg::OFF_GAIN, 32'h0000_0064, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_GAIN, 32'h0000_07d0, aspwm_pkg::RESP_OKAY);
      rd_reg(aspwm_pkg::OFF_GAIN, 32'h0000_03e8, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_GAIN, 32'hffff_f830, aspwm_pkg::RESP_OKAY);
      rd_reg(aspwm_pkg::OFF_GAIN, 32'hffff_fc18, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_OFFSET, 32'hffff_b1e0, aspwm_pkg::RESP_OKAY);
      rd_reg(aspwm_pkg::OFF_OFFSET, 32'hffff_d8f0, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_MAX, 32'h0000_7530, aspwm_pkg::RESP_OKAY);
      rd_reg(aspwm_pkg::OFF_MAX, 32'h0000_4e20, aspwm_pkg::RESP_OKAY);
      wr_reg(8'h40, 32'h0000_1234, aspwm_pkg::RESP_SLVERR);
      rd_reg(8'h40, 32'h0, aspwm_pkg::RESP_SLVERR);
   endtask

   // Scaled value: level times gain in hundredths plus offset
   task automatic t_actual();
      wr_reg(aspwm_pkg::OFF_GAIN, 32'hffff_ff06, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_OFFSET, 32'h0000_02bc, aspwm_pkg::RESP_OKAY);
      input_level_i <= 16'h0064;
      repeat (4) @(posedge clk_i);
      rd_reg(aspwm_pkg::OFF_ACTUAL, 32'h0000_01c2, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_GAIN, 32'h0000_00c8, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_OFFSET, 32'hffff_ff38, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_MAX, 32'h0000_03e8, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_PERIOD, 32'h0000_000a, aspwm_pkg::RESP_OKAY);
      run_pwm(16'h00fa, 300, 0, 1000, 10);
      wr_reg(aspwm_pkg::OFF_GAIN, 32'h0000_0064, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_OFFSET, 32'h0, aspwm_pkg::RESP_OKAY);
   endtask

   // Duty inside, at the top of and below the range; wider range; display digits
   task automatic t_duty();
      run_pwm(16'h012c, 300, 0, 1000, 10);
      run_pwm(16'h03e8, 1000, 0, 1000, 10);
      run_pwm(16'hfffb, -5, 0, 1000, 10);
      wr_reg(aspwm_pkg::OFF_MIN, 32'hffff_fc18, aspwm_pkg::RESP_OKAY);
      run_pwm(16'h0000, 0, -1000, 1000, 10);
      wr_reg(aspwm_pkg::OFF_MIN, 32'h0, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_CTRL, 32'h0000_0030, aspwm_pkg::RESP_OKAY);
      run_pwm(16'h012c, 300, 0, 1000, 10);
   endtask

   // Period from the external value, then a coarser timebase
   task automatic t_period();
      wr_reg(aspwm_pkg::OFF_CTRL, 32'h0000_0001, aspwm_pkg::RESP_OKAY);
      run_pwm(16'h012c, 300, 0, 1000, 5);
      wr_reg(aspwm_pkg::OFF_CTRL, 32'h0000_0002, aspwm_pkg::RESP_OKAY);
      wr_reg(aspwm_pkg::OFF_PERIOD, 32'h0000_0001, aspwm_pkg::RESP_OKAY);
      run_pwm(16'h012c, 300, 0, 1000, 100);
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      t_regs();
      t_actual();
      t_duty();
      t_period();
      results();
   end
endmodule

`default_nettype wire
